//--- src/crc_consts.svh
// register offsets, field positions, reset values and timing counts of the checksum unit
`ifndef CRC_CONSTS_SVH
`define CRC_CONSTS_SVH

`define CRC_OFF_ACCUM       12'h000
`define CRC_OFF_SCRATCH     12'h004
`define CRC_OFF_CONTROL     12'h008
`define CRC_OFF_START       12'h010

`define CRC_CTRL_RESTART    0
`define CRC_CTRL_INPUT_BIT_REVERSAL_LO    5
`define CRC_CTRL_INPUT_BIT_REVERSAL_HI    6
`define CRC_CTRL_OUTPUT_BIT_REVERSAL       7

`define CRC_ACCUM_RESET     32'hFFFFFFFF
`define CRC_START_RESET     32'hFFFFFFFF
`define CRC_SCRATCH_RESET   8'h00
`define CRC_POLY            32'h04C11DB7

`define CRC_CYC_WORD        3'h4
`define CRC_CYC_HALF        3'h2
`define CRC_CYC_BYTE        3'h1

`endif

//--- src/crc_pkg.sv
// types shared by the checksum unit
package crc_pkg;
	typedef enum logic [1:0] {
		REV_NONE,
		REV_BYTE,
		REV_HALF,
		REV_WORD
	} crc_rev_t;

	typedef enum logic [1:0] {
		WID_BYTE,
		WID_HALF,
		WID_WORD
	} crc_width_t;
endpackage

//--- src/crc_bit_reverse.sv
// bit-order reversal of a 32-bit word per byte, half-word or whole word
`timescale 1ns/100ps
module crc_bit_reverse
	import crc_pkg::*;
(
	input  wire logic [31:0]       dataIn,
	input  wire crc_pkg::crc_rev_t mode,
	output logic      [31:0]       dataOut
);
	always_comb begin
		dataOut = dataIn;
		for (int i = 0; i < 32; i++) begin
			case (mode)
				REV_BYTE: dataOut[i] = dataIn[(i & ~7) + 7 - (i & 7)];
				REV_HALF: dataOut[i] = dataIn[(i & ~15) + 15 - (i & 15)];
				REV_WORD: dataOut[i] = dataIn[31 - i];
				default:  dataOut[i] = dataIn[i];
			endcase
		end
	end
endmodule

//--- src/crc_engine.sv
// serial checksum engine: folds one byte of input per clock into the accumulator
`timescale 1ns/100ps
`include "crc_consts.svh"
module crc_engine
	import crc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        preset,
	input  wire logic        load,
	input  wire logic [31:0] loadData,
	input  wire crc_pkg::crc_width_t loadWidth,
	output logic             busy,
	output logic      [31:0] accum
);
	logic [31:0] accum_q, accum_d;
	logic [31:0] shift_q, shift_d;
	logic [2:0]  left_q, left_d;

	// one byte, msb first, through the fixed polynomial
	function automatic logic [31:0] crcByte(input logic [31:0] c, input logic [7:0] b);
		logic [31:0] r;
		r = c ^ {b, 24'h000000};
		for (int k = 0; k < 8; k++) begin
			r = r[31] ? ((r << 1) ^ `CRC_POLY) : (r << 1);
		end
		return r;
	endfunction

	always_comb begin
		accum_d = accum_q;
		shift_d = shift_q;
		left_d  = left_q;
		if (preset) begin
			accum_d = `CRC_ACCUM_RESET;
			left_d  = 3'h0;
		end else if (left_q != 3'h0) begin
			accum_d = crcByte(accum_q, shift_q[31:24]);
			shift_d = {shift_q[23:0], 8'h00};
			left_d  = left_q - 3'h1;
		end else if (load) begin
			// input is left-justified so the msb byte goes first; one byte per cycle
			case (loadWidth)
				WID_BYTE: begin
					shift_d = {loadData[7:0], 24'h000000};
					left_d  = `CRC_CYC_BYTE;
				end
				WID_HALF: begin
					shift_d = {loadData[15:0], 16'h0000};
					left_d  = `CRC_CYC_HALF;
				end
				default: begin
					shift_d = loadData;
					left_d  = `CRC_CYC_WORD;
				end
			endcase
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			accum_q <= `CRC_ACCUM_RESET;
			shift_q <= 32'h00000000;
			left_q  <= 3'h0;
		end else begin
			accum_q <= accum_d;
			shift_q <= shift_d;
			left_q  <= left_d;
		end
	end

	assign busy  = (left_q != 3'h0);
	assign accum = accum_q;
endmodule

//--- src/crc_unit.sv
// checksum unit top: APB slave, control, scratch and start-value registers
//
// Contract
// - An 8-bit scratch field sits in bits 7:0 of the scratch register, upper bits read zero.
// - The restart bit leaves the scratch byte unchanged.
// - The scratch byte never feeds the checksum computation.
// - After reset the scratch register reads zero.
// - Writing one to control bit 0 presets the accumulator to all ones.
// - The restart bit can only be set by software and clears itself, reading back zero.
// - Control bits 6:5 select input reversal per byte, half-word or word; bit 7 reverses output.
// - A full 32-bit read/write start-value register holds the checksum starting value; the preset loads all ones and never reads it.
// - After reset the start-value register holds all ones.
// - The engine uses the fixed Ethernet generator polynomial.
// - One input takes four cycles for a word, two for a half-word, one for a byte.
// - Each accumulator write folds data into the previous result; a read returns it.
//
// Implementation choice: register access over APB.
`timescale 1ns/100ps
`include "crc_consts.svh"
module crc_unit
	import crc_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        reset_n,
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic             pready,
	output logic      [31:0] prdata,
	output logic             pslverr
);
	import crc_pkg::*;

	logic [7:0]  scratch_q, scratch_d;
	logic [1:0]  revIn_q, revIn_d;
	logic        revOut_q, revOut_d;
	logic        restart_q, restart_d;
	logic [31:0] start_q, start_d;
	logic        ready_q, ready_d;
	logic [31:0] rdata_q, rdata_d;
	logic        err_q, err_d;

	logic        engBusy;
	logic [31:0] engAccum;
	logic [31:0] inRev;
	logic [31:0] outRev;
	logic        engLoad;
	logic        enginePreset;
	crc_width_t  loadWidth;
	logic [31:0] loadData;

	logic        accessPh;
	logic        hitAccum;
	logic        hitScratch;
	logic        hitControl;
	logic        hitStart;
	logic        mapped;

	assign accessPh   = psel && penable;
	assign hitAccum   = (paddr == `CRC_OFF_ACCUM);
	assign hitScratch = (paddr == `CRC_OFF_SCRATCH);
	assign hitControl = (paddr == `CRC_OFF_CONTROL);
	assign hitStart   = (paddr == `CRC_OFF_START);
	assign mapped     = hitAccum || hitScratch || hitControl || hitStart;

	// width of an accumulator write from its strobes; right-aligned only
	function automatic crc_width_t strbWidth(input logic [3:0] s);
		case (s)
			4'h1:    return WID_BYTE;
			4'h3:    return WID_HALF;
			default: return WID_WORD;
		endcase
	endfunction

	// reversal is applied to the full word, then the part holding the reversed narrow input is taken
	crc_bit_reverse uInRev (
		.dataIn  (pwdata),
		.mode    (crc_rev_t'(revIn_q)),
		.dataOut (inRev)
	);

	crc_bit_reverse uOutRev (
		.dataIn  (engAccum),
		.mode    (revOut_q ? REV_WORD : REV_NONE),
		.dataOut (outRev)
	);

	assign loadWidth = strbWidth(pstrb);
	// a byte reversed per word lands in the top byte; bring it back right-aligned
	always_comb begin
		loadData = inRev;
		if (crc_rev_t'(revIn_q) == REV_WORD) begin
			case (loadWidth)
				WID_BYTE: loadData = {24'h000000, inRev[31:24]};
				WID_HALF: loadData = {16'h0000, inRev[31:16]};
				default:  loadData = inRev;
			endcase
		end else if (crc_rev_t'(revIn_q) == REV_HALF && loadWidth == WID_BYTE) begin
			loadData = {24'h000000, inRev[15:8]};
		end
	end

	// the write is committed at the access edge after the one that raises pready, while pready is high
	assign engLoad      = accessPh && ready_q && pwrite && hitAccum;
	assign enginePreset = restart_q;

	crc_engine uEngine (
		.clk       (clk),
		.reset_n   (reset_n),
		.preset    (enginePreset),
		.load      (engLoad),
		.loadData  (loadData),
		.loadWidth (loadWidth),
		.busy      (engBusy),
		.accum     (engAccum)
	);

	always_comb begin
		scratch_d = scratch_q;
		revIn_d   = revIn_q;
		revOut_d  = revOut_q;
		start_d   = start_q;
		restart_d = 1'b0;
		ready_d   = 1'b0;
		rdata_d   = rdata_q;
		err_d     = 1'b0;
		if (accessPh && !ready_q) begin
			// stall accumulator access while the engine folds the previous input
			if (!(hitAccum && engBusy) && !restart_q) begin
				ready_d = 1'b1;
				err_d   = !mapped;
				rdata_d = 32'h00000000;
				if (!pwrite) begin
					case (1'b1)
						hitAccum:   rdata_d = outRev;
						hitScratch: rdata_d = {24'h000000, scratch_q};
						hitControl: rdata_d = {24'h000000, revOut_q, revIn_q, 5'h00};
						hitStart:   rdata_d = start_q;
						default:    rdata_d = 32'h00000000;
					endcase
				end
			end
		end
		if (accessPh && ready_q && pwrite) begin
			if (hitScratch) begin
				scratch_d = pwdata[7:0];
			end
			if (hitControl) begin
				revIn_d   = pwdata[`CRC_CTRL_INPUT_BIT_REVERSAL_HI:`CRC_CTRL_INPUT_BIT_REVERSAL_LO];
				revOut_d  = pwdata[`CRC_CTRL_OUTPUT_BIT_REVERSAL];
				restart_d = pwdata[`CRC_CTRL_RESTART];
			end
			if (hitStart) begin
				start_d = pwdata;
			end
		end
	end

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			scratch_q <= `CRC_SCRATCH_RESET;
			revIn_q   <= 2'h0;
			revOut_q  <= 1'b0;
			restart_q <= 1'b0;
			start_q   <= `CRC_START_RESET;
			ready_q   <= 1'b0;
			rdata_q   <= 32'h00000000;
			err_q     <= 1'b0;
		end else begin
			scratch_q <= scratch_d;
			revIn_q   <= revIn_d;
			revOut_q  <= revOut_d;
			restart_q <= restart_d;
			start_q   <= start_d;
			ready_q   <= ready_d;
			rdata_q   <= rdata_d;
			err_q     <= err_d;
		end
	end

	assign pready  = ready_q;
	assign prdata  = rdata_q;
	assign pslverr = err_q;
endmodule

//--- dv/crc_unit_checker.sv
// assertions on the checksum unit's register bus port
`timescale 1ns/100ps
`include "crc_consts.svh"
module crc_unit_checker (
	input wire logic        clk,
	input wire logic        reset_n,
	input wire logic        psel,
	input wire logic        penable,
	input wire logic        pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic        pready,
	input wire logic [31:0] prdata,
	input wire logic        pslverr
);
	logic        fresh_q;
	logic [7:0]  scr_q;
	logic [2:0]  ctl_q;
	logic [31:0] start_q;
	wire logic   done = psel && penable && pready;
	wire logic   wrDone = done && pwrite;
	wire logic   rdDone = done && !pwrite;

	// shadow of what software wrote, so read data can be tied to its cause
	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			fresh_q <= 1'h1;
			scr_q <= 8'h00;
			ctl_q <= 3'h0;
			start_q <= 32'hFFFFFFFF;
		end else if (wrDone) begin
			if (paddr == `CRC_OFF_SCRATCH) scr_q <= pwdata[7:0];
			if (paddr == `CRC_OFF_CONTROL) ctl_q <= pwdata[7:5];
			if (paddr == `CRC_OFF_START) start_q <= pwdata;
			if (paddr == `CRC_OFF_CONTROL && pwdata[0]) fresh_q <= 1'h1;
			if (paddr == `CRC_OFF_ACCUM) fresh_q <= 1'h0;
		end
	end

	default clocking @(posedge clk); endclocking
	default disable iff (!reset_n);

	AST_ACCESS_ONLY: assert property (pready |-> psel && penable)
		else $error("answer outside an access phase");
	AST_READY_PULSE: assert property (pready |=> !pready)
		else $error("ready longer than one cycle");
	AST_UNMAPPED_ERR: assert property (done |-> pslverr == !(paddr inside {12'h000, 12'h004,
		12'h008, 12'h010})) else $error("error flag does not match the address");
	AST_SCRATCH_UPPER: assert property (rdDone && paddr == `CRC_OFF_SCRATCH |-> prdata[31:8] == 24'h0)
		else $error("scratch upper bits not zero");
	AST_SCRATCH_HOLD: assert property (rdDone && paddr == `CRC_OFF_SCRATCH |-> prdata[7:0] == scr_q)
		else $error("scratch byte lost");
	AST_CTRL_READ: assert property (rdDone && paddr == `CRC_OFF_CONTROL |-> prdata == {24'h0, ctl_q, 5'h0})
		else $error("control read back wrong");
	AST_START_READ: assert property (rdDone && paddr == `CRC_OFF_START |-> prdata == start_q)
		else $error("start value read back wrong");
	AST_RESTART_PRESET: assert property (rdDone && paddr == `CRC_OFF_ACCUM && fresh_q |-> prdata == 32'hFFFFFFFF)
		else $error("accumulator not preset");

	cover property (wrDone && paddr == `CRC_OFF_CONTROL && pwdata[0]);
	cover property (rdDone && paddr == `CRC_OFF_ACCUM);
	cover property (done && pslverr);
endmodule

bind crc_unit crc_unit_checker regChk (.clk(clk), .reset_n(reset_n), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready),
	.prdata(prdata), .pslverr(pslverr));

//--- dv/crc_apb_master.sv
// bus master model standing in for the processor on the register bus
`timescale 1ns/100ps
module crc_apb_master (
	input  wire logic        clk,
	input  wire logic        pready,
	input  wire logic [31:0] prdata,
	input  wire logic        pslverr,
	output logic             psel = 1'h0,
	output logic             penable = 1'h0,
	output logic             pwrite = 1'h0,
	output logic      [11:0] paddr = 12'h000,
	output logic      [31:0] pwdata = 32'h0,
	output logic      [3:0]  pstrb = 4'hF
);
	task xfer(input logic w, input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
		output logic [31:0] r, output logic e);
		@(posedge clk);
		psel <= 1'h1;
		penable <= 1'h0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge clk);
		penable <= 1'h1;
		// no wait-state count is assumed; only the bench timeout ends a hung access
		do begin
			@(posedge clk);
		end while (pready !== 1'h1);
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
		// released data must not look like the last value
		pwdata <= ~d;
	endtask
endmodule

//--- dv/crc_control_scratch_init_bench.sv
// self-checking bench of the checksum unit's registers
`timescale 1ns/100ps
`include "crc_consts.svh"
module crc_control_scratch_init_bench;
	logic        clk = 1'h0;
	logic        reset_n = 1'h0;
	logic        psel, penable, pwrite, pready, pslverr, er;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0]  pstrb;
	int          errCount = 0;
	int          checkCount = 0;
	int          cyc = 0;

	always #25 clk = ~clk;
	crc_unit uut (.clk(clk), .reset_n(reset_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .pready(pready),
		.prdata(prdata), .pslverr(pslverr));
	crc_apb_master mst (.clk(clk), .pready(pready), .prdata(prdata), .pslverr(pslverr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb));

	function automatic logic [31:0] fold(input logic [31:0] c, input logic [31:0] d, input int n);
		for (int i = n - 1; i >= 0; i--) c = {c[30:0], 1'h0} ^ ((c[31] ^ d[i]) ? `CRC_POLY : 32'h0);
		return c;
	endfunction
	// reverse bit order inside groups of g bits; g of zero leaves data as is
	function automatic logic [31:0] rev(input logic [31:0] d, input int g);
		logic [31:0] r;
		r = d;
		for (int i = 0; i < 32; i++) if (g > 0) r[i] = d[(i / g) * g + g - 1 - i % g];
		return r;
	endfunction

	task chk(input logic [31:0] seen, input logic [31:0] exp);
		checkCount++;
		if (seen !== exp) begin
			errCount++;
			$display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task endOfTest();
		if (errCount == 0 && checkCount > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s);
		mst.xfer(1'h1, a, d, s, rd, er);
	endtask
	task rdv(input logic [11:0] a);
		mst.xfer(1'h0, a, 32'h0, 4'hF, rd, er);
	endtask

	task tReset();
		rdv(`CRC_OFF_ACCUM);
		chk(rd, 32'hFFFFFFFF);
		rdv(`CRC_OFF_SCRATCH);
		chk(rd, 32'h00000000);
		rdv(`CRC_OFF_START);
		chk(rd, 32'hFFFFFFFF);
	endtask
	task tScratchStart();
		wr(`CRC_OFF_SCRATCH, 32'hFFFFFF5A, 4'hF);
		rdv(`CRC_OFF_SCRATCH);
		chk(rd, 32'h0000005A);
		wr(`CRC_OFF_START, 32'h1234ABCD, 4'hF);
		rdv(`CRC_OFF_START);
		chk(rd, 32'h1234ABCD);
	endtask
	task tModes();
		logic [31:0] e;
		logic [31:0] c;
		for (int k = 0; k < 8; k++) begin
			c = {24'h0, k[0], k[2:1], 5'h0};
			wr(`CRC_OFF_CONTROL, c | 32'h1, 4'hF);
			rdv(`CRC_OFF_CONTROL);
			chk(rd, c);
			wr(`CRC_OFF_ACCUM, 32'hC0FFEE15, 4'hF);
			e = fold(32'hFFFFFFFF, rev(32'hC0FFEE15, (k[2:1] == 0) ? 0 : 4 << k[2:1]), 32);
			rdv(`CRC_OFF_ACCUM);
			chk(rd, k[0] ? rev(e, 32) : e);
			wr(`CRC_OFF_CONTROL, 32'h0, 4'hF);
			rdv(`CRC_OFF_ACCUM);
			chk(rd, e);
		end
		rdv(`CRC_OFF_SCRATCH);
		chk(rd, 32'h0000005A);
	endtask
	task tWidths();
		wr(`CRC_OFF_CONTROL, 32'h1, 4'hF);
		wr(`CRC_OFF_ACCUM, 32'h89ABCDEF, 4'hF);
		// a scratch write in the middle of a checksum must not disturb it
		wr(`CRC_OFF_SCRATCH, 32'h000000C3, 4'hF);
		wr(`CRC_OFF_ACCUM, 32'h00005A3C, 4'h3);
		wr(`CRC_OFF_ACCUM, 32'h000000A7, 4'h1);
		rdv(`CRC_OFF_ACCUM);
		chk(rd, fold(fold(fold(32'hFFFFFFFF, 32'h89ABCDEF, 32), 32'h5A3C, 16), 32'hA7, 8));
		// narrow writes under half-word and word reversal reverse the whole narrow unit
		for (int m = 2; m < 4; m++) begin
			wr(`CRC_OFF_CONTROL, {25'h0, m[1:0], 5'h01}, 4'hF);
			wr(`CRC_OFF_ACCUM, 32'h00005A3C, 4'h3);
			wr(`CRC_OFF_ACCUM, 32'h000000A7, 4'h1);
			rdv(`CRC_OFF_ACCUM);
			chk(rd, fold(fold(32'hFFFFFFFF, rev(32'h5A3C, 16), 16), rev(32'hA7, 8), 8));
		end
	endtask
	task tUnmapped();
		rdv(12'h00C);
		chk({31'h0, er}, 32'h1);
		chk(rd, 32'h00000000);
		wr(12'h014, 32'h0, 4'hF);
		chk({31'h0, er}, 32'h1);
	endtask

	always @(posedge clk) begin
		cyc++;
		if (cyc == 5000) begin
			errCount++;
			endOfTest();
		end
	end
	initial begin
		repeat (10) @(posedge clk);
		reset_n <= 1'h1;
		tReset();
		tScratchStart();
		tModes();
		tWidths();
		tUnmapped();
		endOfTest();
	end
endmodule
